/* verilog/crp_defs.svh */
// crp_defs.svh: constants for the completer request packetizer
// assumes a 128-bit stream (four Dwords a beat) and a 50 MHz clk_sys
`ifndef CRP_DEFS_SVH
`define CRP_DEFS_SVH

// stream geometry
`define CRP_DATA_W        128
`define CRP_BEAT_DW       4
`define CRP_IF_BYTES      16
`define CRP_DESC_BYTES    16
`define CRP_CNT_W         9
`define CRP_MAX_DW        11'h100

// descriptor field positions
`define CRP_F_AT_HI       1
`define CRP_F_AT_LO       0
`define CRP_F_ADDR_HI     63
`define CRP_F_ADDR_LO     2
`define CRP_F_ADDRU_HI    63
`define CRP_F_ADDRU_LO    32
`define CRP_F_SNOOP_HI    15
`define CRP_F_SNOOP_LO    0
`define CRP_F_NOSNP_HI    31
`define CRP_F_NOSNP_LO    16
`define CRP_F_OBFF_HI     35
`define CRP_F_OBFF_LO     32
`define CRP_F_DEST_HI     15
`define CRP_F_DEST_LO     0
`define CRP_F_VHDR_HI     63
`define CRP_F_VHDR_LO     32
`define CRP_F_ATS_HI      63
`define CRP_F_ATS_LO      0
`define CRP_F_COUNT_HI    74
`define CRP_F_COUNT_LO    64
`define CRP_F_TYPE_HI     78
`define CRP_F_TYPE_LO     75
`define CRP_F_RID_HI      95
`define CRP_F_RID_LO      80
`define CRP_F_TAG_HI      103
`define CRP_F_TAG_LO      96
`define CRP_F_FUNC_HI     111
`define CRP_F_FUNC_LO     104
`define CRP_F_BAR_HI      114
`define CRP_F_BAR_LO      112
`define CRP_F_APER_HI     120
`define CRP_F_APER_LO     115
`define CRP_F_TC_HI       123
`define CRP_F_TC_LO       121
`define CRP_F_ATTR_HI     126
`define CRP_F_ATTR_LO     124
`define CRP_F_IDO         126

// request type codes
`define CRP_T_MEM_RD      4'h0
`define CRP_T_MEM_WR      4'h1
`define CRP_T_IO_RD       4'h2
`define CRP_T_IO_WR       4'h3
`define CRP_T_FETCH_ADD   4'h4
`define CRP_T_SWAP        4'h5
`define CRP_T_CAS         4'h6
`define CRP_T_LOCK_RD     4'h7
`define CRP_T_MSG         4'hC
`define CRP_T_VENDOR      4'hD
`define CRP_T_ATS         4'hE

// message routing and hint codes
`define CRP_ROUTE_BY_ID   3'h2
`define CRP_OBFF_ACTIVE   4'hF
`define CRP_OBFF_PATH     4'h1
`define CRP_OBFF_IDLE     4'h0

`endif

/* verilog/crp_pkg.sv */
// crp_pkg: types shared by the completer request packetizer
// assumes the constants of crp_defs.svh alongside
package crp_pkg;

	// packetizer sequencer, one-hot
	typedef enum logic [1:0] {
		CRP_IDLE = 2'b01,
		CRP_PKT  = 2'b10
	} crp_state_t;

endpackage

/* verilog/crp_completer_request_packetizer.sv */
// crp_completer_request_packetizer: turns received requests into descriptor plus payload packets
// assumes request fields and payload beats arrive on clk_sys from a store-and-forward receive buffer
`include "crp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module crp_completer_request_packetizer
(
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,

	// configuration, static while packets flow
	input  wire logic                      addrAlignMode,
	input  wire logic                      ariEnable,

	// request from the link side
	input  wire logic                      reqValid,
	output logic                           reqReady,
	input  wire logic [3:0]                reqType,
	input  wire logic [1:0]                reqAddrType,
	input  wire logic [63:0]               reqAddr,
	input  wire logic                      reqAddr64,
	input  wire logic [10:0]               reqDwordCount,
	input  wire logic                      reqZeroLength,
	input  wire logic [3:0]                reqFirstBe,
	input  wire logic [3:0]                reqLastBe,
	input  wire logic [15:0]               reqRequesterId,
	input  wire logic [7:0]                reqTag,
	input  wire logic [7:0]                reqTargetFunction,
	input  wire logic [2:0]                reqBarId,
	input  wire logic [5:0]                reqBarAperture,
	input  wire logic [2:0]                reqTrafficClass,
	input  wire logic [2:0]                reqAttr,
	input  wire logic [7:0]                reqMsgCode,
	input  wire logic [2:0]                reqMsgRouting,
	input  wire logic                      reqLtrMsg,
	input  wire logic                      reqObffMsg,
	input  wire logic [15:0]               reqSnoopLatency,
	input  wire logic [15:0]               reqNoSnoopLatency,
	input  wire logic [3:0]                reqObffCode,
	input  wire logic [15:0]               reqDestId,
	input  wire logic [31:0]               reqVendorHdr,
	input  wire logic [63:0]               reqAtsHeader,

	// payload beats, Dword 0 in bits 31:0
	input  wire logic                      pdValid,
	output logic                           pdReady,
	input  wire logic [`CRP_DATA_W-1:0]    pdData,

	// completer request stream
	output logic                           completerReqValid,
	input  wire logic                      completerReqReady,
	output logic [`CRP_DATA_W-1:0]         completerReqData,
	output logic [`CRP_BEAT_DW-1:0]        completerReqDwordKeep,
	output logic                           completerReqLast,
	output logic                           completerReqSop,
	output logic [3:0]                     firstDwordByteEnables,
	output logic [3:0]                     lastDwordByteEnables
);

	crp_pkg::crp_state_t state_q;
	crp_pkg::crp_state_t state_d;

	logic                        outValid_q;
	logic [`CRP_DATA_W-1:0]      outData_q;
	logic [`CRP_BEAT_DW-1:0]     outKeep_q;
	logic                        outLast_q;
	logic                        outSop_q;
	logic [3:0]                  firstBe_q;
	logic [3:0]                  lastBe_q;
	logic [`CRP_DATA_W-1:0]      prev_q;
	logic [1:0]                  shift_q;
	logic [`CRP_CNT_W-1:0]       remOut_q;
	logic [`CRP_CNT_W-1:0]       remIn_q;

	// request classification
	wire isMemClass = (reqType[3] == 1'b0);
	wire isIo       = (reqType == `CRP_T_IO_RD) || (reqType == `CRP_T_IO_WR);
	wire isGenMsg   = (reqType == `CRP_T_MSG);
	wire isVendor   = (reqType == `CRP_T_VENDOR);
	wire isAts      = (reqType == `CRP_T_ATS);
	wire isMsg      = isGenMsg || isVendor || isAts;
	wire isMemRw    = (reqType == `CRP_T_MEM_RD) || (reqType == `CRP_T_MEM_WR);
	wire hasPayload = (reqType == `CRP_T_MEM_WR) || (reqType == `CRP_T_IO_WR)
		|| (reqType == `CRP_T_FETCH_ADD) || (reqType == `CRP_T_SWAP)
		|| (reqType == `CRP_T_CAS) || isMsg;

	// count field: I/O is one Dword, zero-length memory reports one
	wire zeroLen = isMemRw && reqZeroLength;
	wire [10:0] countField = (isIo || zeroLen) ? 11'h001 : reqDwordCount;

	// payload Dwords actually carried; a zero-length write still moves one Dword
	wire [`CRP_CNT_W-1:0] payloadDw = hasPayload ? countField[`CRP_CNT_W-1:0] : 9'h000;

	// lane offset in Dwords; address-aligned mode uses lane reqAddr[3:2], Dword-aligned mode and messages use lane 0
	wire [1:0] alignDw = (addrAlignMode && !isMsg) ? reqAddr[3:2] : 2'h0;

	// attribute mask: ID-based ordering dropped for I/O requests
	wire [2:0] attrField = isIo ? {1'b0, reqAttr[1:0]} : reqAttr;

	// function field: messages reuse it for the message code
	wire [7:0] funcMasked = ariEnable ? reqTargetFunction : {5'h00, reqTargetFunction[2:0]};
	wire [7:0] funcField  = isMsg ? reqMsgCode : (isMemClass ? funcMasked : 8'h00);
	wire [2:0] barField   = isMsg ? reqMsgRouting : (isMemClass ? reqBarId : 3'h0);
	wire [5:0] aperField  = isMemClass ? reqBarAperture : 6'h00;

	// byte enables on the sideband; zero-length requests clear both
	wire [3:0] firstBeSel = zeroLen ? 4'h0 : reqFirstBe;
	wire [3:0] lastBeSel  = zeroLen ? 4'h0 : reqLastBe;

	// descriptor assembly, one field at a time
	logic [`CRP_DATA_W-1:0] descWord;
	always_comb
	begin
		descWord = '0;
		if (isMemClass)
		begin
			descWord[`CRP_F_AT_HI:`CRP_F_AT_LO] = reqAddrType;
			descWord[`CRP_F_ADDR_HI:`CRP_F_ADDR_LO] = reqAddr[63:2];
			if (!reqAddr64)
			begin
				descWord[`CRP_F_ADDRU_HI:`CRP_F_ADDRU_LO] = 32'h00000000;
			end
		end
		else if (isAts)
		begin
			descWord[`CRP_F_ATS_HI:`CRP_F_ATS_LO] = reqAtsHeader;
		end
		else if (isVendor)
		begin
			descWord[`CRP_F_VHDR_HI:`CRP_F_VHDR_LO] = reqVendorHdr;
			if (reqMsgRouting == `CRP_ROUTE_BY_ID)
			begin
				descWord[`CRP_F_DEST_HI:`CRP_F_DEST_LO] = reqDestId;
			end
		end
		else if (isGenMsg && reqLtrMsg)
		begin
			descWord[`CRP_F_SNOOP_HI:`CRP_F_SNOOP_LO] = reqSnoopLatency;
			descWord[`CRP_F_NOSNP_HI:`CRP_F_NOSNP_LO] = reqNoSnoopLatency;
		end
		else if (isGenMsg && reqObffMsg)
		begin
			descWord[`CRP_F_OBFF_HI:`CRP_F_OBFF_LO] = reqObffCode;
		end
		descWord[`CRP_F_COUNT_HI:`CRP_F_COUNT_LO] = countField;
		descWord[`CRP_F_TYPE_HI:`CRP_F_TYPE_LO] = reqType;
		descWord[`CRP_F_RID_HI:`CRP_F_RID_LO] = reqRequesterId;
		descWord[`CRP_F_TAG_HI:`CRP_F_TAG_LO] = reqTag;
		descWord[`CRP_F_FUNC_HI:`CRP_F_FUNC_LO] = funcField;
		descWord[`CRP_F_BAR_HI:`CRP_F_BAR_LO] = barField;
		descWord[`CRP_F_APER_HI:`CRP_F_APER_LO] = aperField;
		descWord[`CRP_F_TC_HI:`CRP_F_TC_LO] = reqTrafficClass;
		descWord[`CRP_F_ATTR_HI:`CRP_F_ATTR_LO] = attrField;
	end

	// handshake terms; the output slot frees when empty or when its beat is taken
	wire slotFree  = !outValid_q || completerReqReady;
	wire moreBeats = (remOut_q != 9'h000);
	wire needIn    = (remIn_q != 9'h000);
	wire takeReq   = (state_q == crp_pkg::CRP_IDLE) && reqValid && reqReady;
	wire loadBeat  = (state_q == crp_pkg::CRP_PKT) && moreBeats && slotFree && (!needIn || pdValid);
	wire lastTaken = outValid_q && completerReqReady && outLast_q;

	assign reqReady = (state_q == crp_pkg::CRP_IDLE) && !outValid_q;
	assign pdReady  = (state_q == crp_pkg::CRP_PKT) && moreBeats && needIn && slotFree;

	// payload realignment: current beat shifted up over the tail of the previous one
	wire [`CRP_DATA_W-1:0] inBeat = needIn ? pdData : '0;
	wire [`CRP_DATA_W-1:0] shiftedBeat =
		(shift_q == 2'h0) ? inBeat :
		(shift_q == 2'h1) ? {inBeat[95:0], prev_q[127:96]} :
		(shift_q == 2'h2) ? {inBeat[63:0], prev_q[127:64]} :
		                    {inBeat[31:0], prev_q[127:32]};

	// keep for this beat; leading gap Dwords count as kept
	wire fullBeat = (remOut_q >= 9'h004);
	wire [`CRP_BEAT_DW-1:0] beatKeep =
		fullBeat                ? 4'hF :
		(remOut_q[1:0] == 2'h3) ? 4'h7 :
		(remOut_q[1:0] == 2'h2) ? 4'h3 : 4'h1;
	wire [`CRP_CNT_W-1:0] takeOut = fullBeat ? 9'h004 : remOut_q;
	wire [`CRP_CNT_W-1:0] takeIn  = (remIn_q >= 9'h004) ? 9'h004 : remIn_q;

	// sequencer
	always_comb
	begin
		case (state_q)
			crp_pkg::CRP_IDLE: state_d = takeReq ? crp_pkg::CRP_PKT : crp_pkg::CRP_IDLE;
			crp_pkg::CRP_PKT:  state_d = lastTaken ? crp_pkg::CRP_IDLE : crp_pkg::CRP_PKT;
			default:           state_d = crp_pkg::CRP_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			state_q <= crp_pkg::CRP_IDLE;
		else
			state_q <= state_d;
	end

	// output valid: set with the descriptor and each loaded beat, cleared when a beat is taken and no new beat loads
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			outValid_q <= 1'b0;
		else if (takeReq || loadBeat)
			outValid_q <= 1'b1;
		else if (completerReqReady)
			outValid_q <= 1'b0;
	end

	// beat contents change only when a new beat loads into a free slot
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			outData_q <= '0;
			outKeep_q <= 4'h0;
			outLast_q <= 1'b0;
			outSop_q  <= 1'b0;
		end
		else if (takeReq)
		begin
			outData_q <= descWord;
			outKeep_q <= 4'hF;
			outLast_q <= (payloadDw == 9'h000);
			outSop_q  <= 1'b1;
		end
		else if (loadBeat)
		begin
			outData_q <= shiftedBeat;
			outKeep_q <= beatKeep;
			outLast_q <= !fullBeat || (remOut_q == 9'h004);
			outSop_q  <= 1'b0;
		end
	end

	// sideband byte enables, captured once per packet
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			firstBe_q <= 4'h0;
			lastBe_q  <= 4'h0;
		end
		else if (takeReq)
		begin
			firstBe_q <= firstBeSel;
			lastBe_q  <= lastBeSel;
		end
	end

	// realignment state; prev starts as zeros so the gap Dwords read as null
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_q   <= '0;
			shift_q  <= 2'h0;
			remOut_q <= 9'h000;
			remIn_q  <= 9'h000;
		end
		else if (takeReq)
		begin
			prev_q   <= '0;
			shift_q  <= alignDw;
			remOut_q <= (payloadDw == 9'h000) ? 9'h000 : 9'(payloadDw + {7'h00, alignDw});
			remIn_q  <= payloadDw;
		end
		else if (loadBeat)
		begin
			prev_q   <= inBeat;
			remOut_q <= 9'(remOut_q - takeOut);
			remIn_q  <= 9'(remIn_q - takeIn);
		end
	end

	// stream outputs straight from the beat registers
	assign completerReqValid     = outValid_q;
	assign completerReqData      = outData_q;
	assign completerReqDwordKeep = outKeep_q;
	assign completerReqLast      = outLast_q;
	assign completerReqSop       = outSop_q;
	assign firstDwordByteEnables = firstBe_q;
	assign lastDwordByteEnables  = lastBe_q;

endmodule

`default_nettype wire

/* dv/crp_packetizer_asserts.sv */
// checker: stream relations of the request packetizer
// assumes bind onto the packetizer top, one clock domain
`include "crp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module crp_packetizer_asserts
(
	// clock and reset
	input wire logic                   clk_sys,
	input wire logic                   resetn,
	// request handshake
	input wire logic                   reqValid,
	input wire logic                   reqReady,
	// completer request stream
	input wire logic                   completerReqValid,
	input wire logic                   completerReqReady,
	input wire logic [`CRP_DATA_W-1:0] completerReqData,
	input wire logic [3:0]             completerReqDwordKeep,
	input wire logic                   completerReqLast,
	input wire logic                   completerReqSop
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// descriptor beat fields
	wire logic [3:0] dType = completerReqData[78:75];
	wire logic       dHead = completerReqValid && completerReqSop;
	sequence s_taken;
		reqValid && reqReady;
	endsequence
	sequence s_desc;
		dHead && completerReqDwordKeep == 4'hF;
	endsequence
	chk_desc_follows: assert property (s_taken |=> s_desc)
		else $error("no descriptor beat after request");
	chk_beat_hold: assert property (completerReqValid && !completerReqReady |=> completerReqValid
		&& $stable({completerReqData, completerReqDwordKeep, completerReqLast, completerReqSop}))
		else $error("stalled beat changed");
	chk_no_gap: assert property (completerReqValid && !completerReqLast |=> completerReqValid)
		else $error("valid dropped inside packet");
	chk_keep_shape: assert property (completerReqValid |-> completerReqDwordKeep inside {4'h1, 4'h3, 4'h7, 4'hF})
		else $error("keep not contiguous");
	chk_partial_last: assert property (completerReqValid && completerReqDwordKeep != 4'hF |-> completerReqLast)
		else $error("partial beat before end");
	chk_last_ends: assert property (completerReqValid && completerReqReady && completerReqLast |=> !completerReqValid)
		else $error("beat right after last");
	chk_read_single: assert property (dHead && dType == `CRP_T_MEM_RD |-> completerReqLast)
		else $error("read packet longer than descriptor");
	chk_io_fields: assert property (dHead && dType inside {`CRP_T_IO_RD, `CRP_T_IO_WR}
		|-> completerReqData[74:64] == 11'h1 && !completerReqData[`CRP_F_IDO])
		else $error("io count or ordering bit wrong");
endmodule
`default_nettype wire

/* dv/crp_stream_sink.sv */
// partner: user logic draining the completer request stream
// assumes the packetizer's clk_sys and resetn
`timescale 1ns/1ps
`default_nettype none
module crp_stream_sink
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	// stream
	input  wire logic         completerReqValid,
	input  wire logic         completerReqSop,
	input  wire logic [127:0] completerReqData,
	output logic              completerReqReady,
	// control and retained fields
	input  wire logic         slowMode,
	output logic [29:0]       keptFields
);
	logic [1:0] stall_q;
	// slow mode drops ready one cycle in three, so stalls land on varied beats
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			stall_q <= 2'h0;
		else
			stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
	end
	assign completerReqReady = resetn && (!slowMode || stall_q != 2'h0);
	// id, tag, class and attributes kept for the completion of a non-posted request
	always_ff @(posedge clk_sys)
	begin
		if (completerReqValid && completerReqReady && completerReqSop)
			keptFields <= {completerReqData[126:121], completerReqData[103:80]};
	end
endmodule
`default_nettype wire

/* dv/tb_completer_request_packetizer.sv */
// testbench: requests into the packetizer, packets drained by a stalling sink
// assumes design files and sink model compiled first
`include "crp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_completer_request_packetizer;
	logic clk_sys, resetn, addrAlignMode, ariEnable, slowMode, reqValid, reqReady, reqAddr64, reqZeroLength;
	logic reqLtrMsg, reqObffMsg, pdValid, pdReady, pdTake, done, completerReqValid, completerReqReady;
	logic completerReqLast, completerReqSop;
	logic [3:0] reqType, reqObffCode, completerReqDwordKeep, firstDwordByteEnables, lastDwordByteEnables, bk[$];
	logic [2:0] reqMsgRouting;
	logic [10:0] reqDwordCount;
	logic [63:0] reqAddr;
	logic [127:0] pdData, completerReqData, bd[$];
	logic [7:0] n, bbe;
	logic [29:0] keptFields;
	logic bl[$];
	int pj, cyc, fail_count, total_checks;
	// distinct bytes per field, moved by the run index so stale fields show
	wire logic [63:0] rf = {n, ~n, n ^ 8'h3C, n + 8'h5B, n ^ 8'h66, n ^ 8'hA5, n + 8'h17, n ^ 8'hF0};
	crp_completer_request_packetizer dut (.clk_sys, .resetn, .addrAlignMode, .ariEnable, .reqValid, .reqReady,
		.reqType, .reqAddrType(rf[9:8]), .reqAddr, .reqAddr64, .reqDwordCount, .reqZeroLength,
		.reqFirstBe(rf[3:0]), .reqLastBe(rf[7:4]), .reqRequesterId(rf[15:0]), .reqTag(rf[23:16]),
		.reqTargetFunction(rf[31:24]), .reqBarId(rf[34:32]), .reqBarAperture(rf[45:40]),
		.reqTrafficClass(rf[50:48]), .reqAttr(rf[58:56]), .reqMsgCode(rf[63:56]), .reqMsgRouting, .reqLtrMsg,
		.reqObffMsg, .reqSnoopLatency(rf[47:32]), .reqNoSnoopLatency(rf[63:48]), .reqObffCode,
		.reqDestId(rf[31:16]), .reqVendorHdr(rf[63:32]), .reqAtsHeader(rf), .pdValid, .pdReady, .pdData,
		.completerReqValid, .completerReqReady, .completerReqData, .completerReqDwordKeep, .completerReqLast,
		.completerReqSop, .firstDwordByteEnables, .lastDwordByteEnables);
	crp_stream_sink sink (.clk_sys, .resetn, .completerReqValid, .completerReqSop, .completerReqData,
		.completerReqReady, .slowMode, .keptFields);
	initial
	begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end
	// upstream payload without gaps, Dword k carries A5000000 + k; watchdog far above the longest run
	always @(posedge clk_sys)
	begin
		pdTake = pdValid && pdReady;
		cyc++;
		if (cyc == 20000)
			stop_test(1);
		#1;
		pj = pj + pdTake;
		pdData = {32'hA5000003 + 4 * pj, 32'hA5000002 + 4 * pj, 32'hA5000001 + 4 * pj, 32'hA5000000 + 4 * pj};
	end
	// every accepted beat is recorded
	always @(posedge clk_sys)
	begin
		if (resetn && completerReqValid && completerReqReady)
		begin
			bd.push_back(completerReqData);
			bk.push_back(completerReqDwordKeep);
			bl.push_back(completerReqLast);
			if (completerReqSop)
				bbe = {firstDwordByteEnables, lastDwordByteEnables};
			done = done | completerReqLast;
		end
	end
	task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one request through to its last beat, then the packet is judged
	task automatic run(input logic [3:0] t, input logic [10:0] c, input logic [63:0] a, input logic a64, zl);
		logic pay, msg;
		int sh, ci, nb, p;
		logic [127:0] d;
		logic [5:0] ta;
		pay = t inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE};
		msg = t inside {`CRP_T_MSG, `CRP_T_VENDOR, `CRP_T_ATS};
		sh = (addrAlignMode && !msg) ? a[3:2] : 0;
		ci = c;
		nb = pay ? 1 + (sh + ci + 3) / 4 : 1;
		n = n + 8'h1;
		{reqType, reqDwordCount, reqAddr, reqAddr64, reqZeroLength} = {t, c, a, a64, zl};
		bd.delete();
		bk.delete();
		bl.delete();
		{done, pj, pdValid, reqValid} = {1'h0, 32'h0, pay, 1'h1};
		for (int w = 0; w < 50 && reqReady !== 1'h1; w++) @(posedge clk_sys) #1;
		@(posedge clk_sys) #1;
		reqValid = 1'h0;
		for (int w = 0; w < 400 && done !== 1'h1; w++) @(posedge clk_sys) #1;
		pdValid = 1'h0;
		chk("done", done, 1'h1);
		d = bd.size() ? bd[0] : '0;
		ta = {t inside {4'h2, 4'h3} ? 1'h0 : rf[58], rf[57:56], rf[50:48]};
		chk("beats", bd.size(), nb);
		chk("type count", d[78:64], {t, c});
		chk("rid tag", d[103:80], rf[23:0]);
		chk("tc attr", d[126:121], ta);
		chk("kept", keptFields, {ta, rf[23:0]});
		chk("be", bbe, zl ? 8'h0 : rf[3:0] << 4 | rf[7:4]);
		if (!t[3])
			chk("addr bar", {d[120:104], d[63:0]}, {rf[45:40], rf[34:32], ariEnable ? rf[31:24] : {5'h0, rf[26:24]},
				a64 ? a[63:32] : 32'h0, a[31:2], rf[9:8]});
		if (msg)
			chk("code route", d[114:104], {reqMsgRouting, rf[63:56]});
		if (t == `CRP_T_MSG)
			chk("ltr obff", reqLtrMsg ? d[31:0] : d[35:32], reqLtrMsg ? {rf[63:32]} : reqObffCode);
		if (t == `CRP_T_VENDOR)
			chk("vendor", {d[63:32], d[15:0]}, {rf[63:32], reqMsgRouting == `CRP_ROUTE_BY_ID ? rf[31:16] : 16'h0});
		if (t == `CRP_T_ATS)
			chk("ats", d[63:0], rf);
		foreach (bd[b])
		begin
			chk("last", bl[b], b == nb - 1);
			for (int i = 0; i < 4 && b > 0; i++)
			begin
				p = (b - 1) * 4 + i - sh;
				chk("keep", bk[b][i], p < ci);
				if (p < ci)
					chk("payload", bd[b][32*i+:32], p < 0 ? 32'h0 : 32'hA5000000 + p);
			end
		end
	endtask
	// every request type code once, Dword-aligned, full target function
	task automatic test_types();
		{addrAlignMode, ariEnable, slowMode, reqLtrMsg, reqObffMsg} = 5'h0C;
		for (int t = 0; t < 16; t++)
			run(4'(t), 11'h1, 64'h00000001_00000F04 + t, 1'h1, 1'h0);
		$display("types done");
	endtask
	// writes at every lane offset, the 256-Dword maximum, zero-length read and write
	task automatic test_writes();
		{addrAlignMode, ariEnable, slowMode} = 3'h4; // ready held high here, so beats go back to back
		run(`CRP_T_MEM_WR, 11'h6, 64'h1234, 1'h1, 1'h0);
		run(`CRP_T_MEM_WR, `CRP_MAX_DW, 64'hFEDCBA98_7654320C, 1'h1, 1'h0);
		run(`CRP_T_SWAP, 11'h2, 64'h8, 1'h1, 1'h0);
		run(`CRP_T_MEM_RD, 11'h1, 64'hFFFFFFFF_00001000, 1'h0, 1'h1);
		run(`CRP_T_MEM_WR, 11'h1, 64'h2000, 1'h0, 1'h1);
		addrAlignMode = 1'h0;
		run(`CRP_T_MEM_WR, 11'h5, 64'h123C, 1'h0, 1'h0);
		$display("writes done");
	endtask
	// latency, hint codes, vendor by id and ATS, payload at lane 0 despite an address
	task automatic test_msgs();
		logic [3:0] hint [3] = '{`CRP_OBFF_ACTIVE, `CRP_OBFF_PATH, `CRP_OBFF_IDLE};
		{addrAlignMode, slowMode, reqLtrMsg, reqObffMsg, reqMsgRouting} = 7'h74;
		run(`CRP_T_MSG, 11'h0, 64'hC, 1'h0, 1'h0);
		{reqLtrMsg, reqObffMsg} = 2'h1;
		foreach (hint[k])
		begin
			reqObffCode = hint[k];
			run(`CRP_T_MSG, 11'h0, 64'h0, 1'h0, 1'h0);
		end
		reqMsgRouting = `CRP_ROUTE_BY_ID;
		run(`CRP_T_VENDOR, 11'h3, 64'hC, 1'h0, 1'h0);
		run(`CRP_T_ATS, 11'h5, 64'h4, 1'h0, 1'h0);
		$display("messages done");
	endtask
	task automatic stop_test(input logic hang);
		fail_count = fail_count + hang;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		{resetn, addrAlignMode, ariEnable, slowMode, reqValid, reqAddr64, reqZeroLength} = 7'h0;
		{reqLtrMsg, reqObffMsg, pdValid, reqType, reqObffCode, reqMsgRouting, reqDwordCount, reqAddr, n} = '0;
		pdData = '0;
		repeat (2) @(posedge clk_sys);
		#1 resetn = 1'h1;
		test_types();
		test_writes();
		test_msgs();
		stop_test(0);
	end
endmodule
bind crp_completer_request_packetizer crp_packetizer_asserts u_chk (.clk_sys, .resetn, .reqValid, .reqReady,
	.completerReqValid, .completerReqReady, .completerReqData, .completerReqDwordKeep, .completerReqLast,
	.completerReqSop);
`default_nettype wire
